// File: common/lbus_pkg.sv
// Constants, states and encodings of the local bus master
package lbus_pkg;
	// Bus timing: one bus cycle spans two periods of the double-rate clock
	localparam int unsigned REF_CLK_PERIOD_NS = 10;
	localparam int unsigned BUS_CYCLE_NS = 20;
	localparam int unsigned BUS_CYCLE_CLKS = BUS_CYCLE_NS / REF_CLK_PERIOD_NS;
	localparam int unsigned RECOVERY_BUS_CYCLES = 1;
	localparam int unsigned RECOVERY_CLKS = RECOVERY_BUS_CYCLES * BUS_CYCLE_CLKS;

	// Bus widths, burst limit and read FIFO depth
	localparam int unsigned LAD_W = 32;
	localparam int unsigned LANES = 4;
	localparam int unsigned MAX_WORDS = 4;
	localparam int unsigned FIFO_DEPTH_DEF = 16;

	// Word count code carried on the two low address lines
	localparam logic [1:0] SIZE_1WORD = 2'h0;
	localparam logic [1:0] SIZE_2WORDS = 2'h1;
	localparam logic [1:0] SIZE_3WORDS = 2'h2;
	localparam logic [1:0] SIZE_4WORDS = 2'h3;

	// Values after reset
	localparam logic [31:0] LAD_RESET = 32'h0000_0000;
	localparam logic [3:0] LANES_OFF = 4'h0;
	localparam logic [1:0] IDX_RESET = 2'h0;

	// Bus states
	typedef enum logic [2:0] {
		IDLE_ST,
		ADDR_ST,
		DATA_ST,
		WAIT_ST,
		RECOV_ST,
		HOLD_ST
	} bus_state_e;
endpackage

// File: common/rd_fifo_if.sv
// Fill side of the read data FIFO, shared by the bus master and the FIFO
`timescale 1ns/1ns
`default_nettype none
interface rd_fifo_if #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned CNT_W = 5
);
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic [CNT_W-1:0] free;

	modport fill (output push_valid, output push_data, input push_ready, input free);
	modport store (input push_valid, input push_data, output push_ready, output free);
endinterface
`default_nettype wire

// File: hdl/bus_phase_gen.sv
// Bus cycle phase from the double-rate clock
`timescale 1ns/1ns
`default_nettype none
module bus_phase_gen (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Phase outputs
	output logic phase_out,
	output logic bus_cycle_clock_out
);
	// Phase 0 is the first half of a bus cycle, the bus cycle clock is low there
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_out <= 1'b0;
			bus_cycle_clock_out <= 1'b0;
		end else begin
			phase_out <= ~phase_out;
			bus_cycle_clock_out <= ~phase_out;
		end
	end
endmodule
`default_nettype wire

// File: hdl/rd_fifo.sv
// Read data FIFO with registered output stage
`timescale 1ns/1ns
`default_nettype none
module rd_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Fill side
	rd_fifo_if.store fill_port,
	// Drain side
	output logic pop_valid_out,
	output logic [WIDTH-1:0] pop_data_out,
	input wire logic pop_ready_in
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	generate
		if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("rd_fifo depth must be a power of two of at least 4");
		end
	endgenerate

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] rptr_r;
	logic [CW-1:0] count_r;
	logic push;
	logic load;

	// Handshakes on both sides
	assign fill_port.push_ready = count_r != CW'(DEPTH);
	assign fill_port.free = CW'(DEPTH) - count_r;
	assign push = fill_port.push_valid && fill_port.push_ready;
	assign load = (count_r != '0) && (!pop_valid_out || pop_ready_in);

	// Storage write
	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem_r[wptr_r] <= fill_port.push_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wptr_r <= '0;
			rptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (load) begin
				rptr_r <= rptr_r + 1'b1;
			end
			count_r <= count_r + CW'(push) - CW'(load);
		end
	end

	// Output stage
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pop_valid_out <= 1'b0;
			pop_data_out <= '0;
		end else if (load) begin
			pop_valid_out <= 1'b1;
			pop_data_out <= mem_r[rptr_r];
		end else if (pop_ready_in) begin
			pop_valid_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: hdl/lbus_master.sv
// Multiplexed local bus master with bursts, wait states, recovery and hold
// Contract
// R1 - Address state drives word address, latch strobe, address strobe, first byte lanes.
// R2 - Read: write_not_read and direction low in address state.
// R3 - Write: write_not_read and direction high in address state.
// R4 - Transceiver enable asserted in data and wait states.
// R5 - No ready in data state inserts wait states until ready.
// R6 - Outside logic asserts low ready when data valid or accepted.
// R7 - Read word captured in the state where ready is seen.
// R8 - One bus cycle recovery follows the final transfer.
// R9 - Write word driven from data state, held through waits until ready.
// R10 - Direction, write flag, transceiver enable steady until state after ready.
// R11 - Bursts up to four words, one word per bus cycle.
// R12 - Byte lanes per word, held until the data state after ready.
// R13 - Byte lanes per word give partial-word writes.
// R14 - Cacheable flag of the address state covers the whole burst.
// R15 - Double-rate clock; bus cycle clock low in first half.
// R16 - Bus request: finish transaction, release bus, assert grant.
// R17 - Hold entered from idle, recovery, data or wait paths; the code enters hold from idle and recovery only.
// R18 - After hold: address state if pending, else idle; the code also goes to idle for a pending read without FIFO room for its burst.
// R19 - Only two masters; more need outside arbitration.
// R20 - Two low address lines carry burst length code.
// R21 - Only adjacent byte lanes asserted; lane 0 is bits 7 to 0.
// R22 - Hold floats outputs, ignores inputs but request; drop clears grant.
// R23 - Idle with no work keeps address strobe and enable off.
// R24 - Ready and bus request sampled at the end of each bus state.
`timescale 1ns/1ns
`default_nettype none
module lbus_master #(
	parameter int unsigned FIFO_DEPTH = lbus_pkg::FIFO_DEPTH_DEF
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Transaction request
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic [29:0] req_addr_in,
	input wire logic [1:0] req_size_in,
	input wire logic req_write_in,
	input wire logic req_cache_in,
	input wire logic [15:0] req_lanes_in,
	input wire logic [127:0] req_wdata_in,
	// Read data
	output logic rd_valid_out,
	output logic [31:0] rd_data_out,
	input wire logic rd_ready_in,
	// Multiplexed address and data lines
	input wire logic [31:0] addr_data_lines_in,
	output logic [31:0] addr_data_lines_out,
	output logic addr_data_lines_oe_out,
	// Three-state strobes
	output logic addr_latch_strobe_n_out,
	output logic addr_latch_strobe_oe_out,
	output logic cacheable_flag_out,
	output logic cacheable_flag_oe_out,
	// Open-drain controls, enable high pulls the pin low
	output logic addr_state_strobe_n_out,
	output logic addr_state_strobe_oe_out,
	output logic write_not_read_out,
	output logic write_not_read_oe_out,
	output logic xfer_direction_out,
	output logic xfer_direction_oe_out,
	output logic data_xcvr_enable_n_out,
	output logic data_xcvr_enable_oe_out,
	output logic [3:0] byte_lane_enables_n_out,
	output logic [3:0] byte_lane_enables_oe_out,
	// Ready and arbitration
	input wire logic ready_n_in,
	input wire logic bus_request_in,
	output logic bus_grant_out,
	output logic bus_cycle_clock_out
);
	localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);

	generate
		if (FIFO_DEPTH < lbus_pkg::MAX_WORDS) begin : g_bad_depth
			$error("lbus_master FIFO must hold a whole burst");
		end
	endgenerate

	lbus_pkg::bus_state_e state_r;
	lbus_pkg::bus_state_e state_nxt;
	logic phase_w;
	logic pend_r;
	logic pend_nxt;
	logic [29:0] p_addr_r;
	logic [1:0] p_size_r;
	logic p_write_r;
	logic p_cache_r;
	logic [15:0] p_lanes_r;
	logic [127:0] p_wdata_r;
	logic [1:0] word_idx_r;
	logic [1:0] idx_nxt;
	logic take;
	logic start;
	logic in_xfer;
	logic ready_seen;
	logic last_word;
	logic word_adv;
	logic room_ok;
	logic od_low_r;
	logic push_valid_r;
	logic [31:0] push_data_r;

	rd_fifo_if #(.WIDTH(32), .CNT_W(CW)) fifo_port ();

	// Adjacent lanes only: fill any gap between the lowest and highest lane
	function automatic logic [3:0] contig(input logic [3:0] lanes);
		logic [3:0] lo;
		logic [3:0] hi;
		lo = '0;
		hi = '0;
		for (int i = 0; i < 4; i++) begin
			lo[i] = (i == 0) ? lanes[0] : (lo[i - 1] | lanes[i]);
		end
		for (int i = 3; i >= 0; i--) begin
			hi[i] = (i == 3) ? lanes[3] : (hi[i + 1] | lanes[i]);
		end
		return lo & hi;
	endfunction

	// Phase and bus cycle clock
	bus_phase_gen u_phase (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.phase_out(phase_w),
		.bus_cycle_clock_out(bus_cycle_clock_out) // see R15
	);

	// Read data buffer
	rd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.fill_port(fifo_port.store),
		.pop_valid_out(rd_valid_out),
		.pop_data_out(rd_data_out),
		.pop_ready_in(rd_ready_in)
	);

	assign fifo_port.push_valid = push_valid_r;
	assign fifo_port.push_data = push_data_r;

	// Decode of the current bus state
	assign in_xfer = (state_r == lbus_pkg::DATA_ST) || (state_r == lbus_pkg::WAIT_ST);
	assign ready_seen = phase_w && in_xfer && !ready_n_in; // see R24
	assign last_word = word_idx_r == p_size_r;
	assign word_adv = ready_seen && !last_word;
	assign take = req_valid_in && req_ready_out;
	assign room_ok = pend_r && (p_write_r || (fifo_port.free >= CW'({1'b0, p_size_r} + 3'h1)));
	assign start = phase_w && (state_nxt == lbus_pkg::ADDR_ST);
	assign idx_nxt = start ? lbus_pkg::IDX_RESET : (word_adv ? word_idx_r + 2'h1 : word_idx_r);

	// Next bus state, decided at the end of each bus cycle
	always_comb begin
		state_nxt = state_r;
		if (phase_w) begin
			case (state_r)
				lbus_pkg::IDLE_ST: begin
					if (bus_request_in) begin
						state_nxt = lbus_pkg::HOLD_ST; // see R16 see R17
					end else if (room_ok) begin
						state_nxt = lbus_pkg::ADDR_ST;
					end else begin
						state_nxt = lbus_pkg::IDLE_ST; // see R23
					end
				end
				lbus_pkg::ADDR_ST: begin
					state_nxt = lbus_pkg::DATA_ST;
				end
				lbus_pkg::DATA_ST, lbus_pkg::WAIT_ST: begin
					if (ready_n_in) begin
						state_nxt = lbus_pkg::WAIT_ST; // see R5
					end else if (last_word) begin
						state_nxt = lbus_pkg::RECOV_ST; // see R8
					end else begin
						state_nxt = lbus_pkg::DATA_ST; // see R11
					end
				end
				lbus_pkg::RECOV_ST: begin
					if (bus_request_in) begin
						state_nxt = lbus_pkg::HOLD_ST; // see R16 see R17
					end else if (room_ok) begin
						state_nxt = lbus_pkg::ADDR_ST;
					end else begin
						state_nxt = lbus_pkg::IDLE_ST;
					end
				end
				lbus_pkg::HOLD_ST: begin
					if (!bus_request_in) begin
						state_nxt = room_ok ? lbus_pkg::ADDR_ST : lbus_pkg::IDLE_ST; // see R18
					end
				end
				default: begin
					state_nxt = lbus_pkg::IDLE_ST;
				end
			endcase
		end
	end

	// State and word index
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= lbus_pkg::IDLE_ST;
			word_idx_r <= lbus_pkg::IDX_RESET;
		end else begin
			state_r <= state_nxt;
			word_idx_r <= idx_nxt;
		end
	end

	// Pending request holds until its final word is done
	always_comb begin
		pend_nxt = pend_r;
		if (take) begin
			pend_nxt = 1'b1;
		end else if (ready_seen && last_word) begin
			pend_nxt = 1'b0;
		end
	end

	// Request capture
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_r <= 1'b0;
			req_ready_out <= 1'b0;
			p_addr_r <= '0;
			p_size_r <= lbus_pkg::SIZE_1WORD;
			p_write_r <= 1'b0;
			p_cache_r <= 1'b0;
			p_lanes_r <= '0;
			p_wdata_r <= '0;
		end else begin
			pend_r <= pend_nxt;
			req_ready_out <= !pend_nxt;
			if (take) begin
				p_addr_r <= req_addr_in;
				p_size_r <= req_size_in;
				p_write_r <= req_write_in;
				p_cache_r <= req_cache_in;
				p_lanes_r <= req_lanes_in;
				p_wdata_r <= req_wdata_in;
			end
		end
	end

	// Address and data lines
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_data_lines_out <= lbus_pkg::LAD_RESET;
			addr_data_lines_oe_out <= 1'b0;
		end else if (phase_w) begin
			case (state_nxt)
				lbus_pkg::ADDR_ST: begin
					addr_data_lines_out <= {p_addr_r, p_size_r}; // see R1 see R20
					addr_data_lines_oe_out <= 1'b1;
				end
				lbus_pkg::DATA_ST: begin
					addr_data_lines_out <= p_wdata_r[{idx_nxt, 5'h00} +: 32]; // see R9
					addr_data_lines_oe_out <= p_write_r;
				end
				lbus_pkg::WAIT_ST: begin
					addr_data_lines_oe_out <= p_write_r; // see R9
				end
				default: begin
					addr_data_lines_oe_out <= 1'b0; // see R8 see R22
				end
			endcase
		end
	end

	// Address strobes, cacheable flag and grant
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_latch_strobe_n_out <= 1'b1;
			addr_latch_strobe_oe_out <= 1'b1;
			addr_state_strobe_oe_out <= 1'b0;
			cacheable_flag_out <= 1'b0;
			cacheable_flag_oe_out <= 1'b1;
			bus_grant_out <= 1'b0;
		end else if (phase_w) begin
			addr_latch_strobe_n_out <= state_nxt != lbus_pkg::ADDR_ST; // see R1
			addr_latch_strobe_oe_out <= state_nxt != lbus_pkg::HOLD_ST; // see R22
			addr_state_strobe_oe_out <= state_nxt == lbus_pkg::ADDR_ST; // see R1 see R23
			if (state_nxt == lbus_pkg::ADDR_ST) begin
				cacheable_flag_out <= p_cache_r; // see R14
			end
			cacheable_flag_oe_out <= state_nxt != lbus_pkg::HOLD_ST;
			bus_grant_out <= state_nxt == lbus_pkg::HOLD_ST; // see R16 see R22
		end
	end

	// Direction, write flag, transceiver enable and byte lanes
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			write_not_read_oe_out <= 1'b0;
			xfer_direction_oe_out <= 1'b0;
			data_xcvr_enable_oe_out <= 1'b0;
			byte_lane_enables_oe_out <= lbus_pkg::LANES_OFF;
		end else if (phase_w) begin
			case (state_nxt)
				lbus_pkg::ADDR_ST, lbus_pkg::DATA_ST, lbus_pkg::WAIT_ST: begin
					write_not_read_oe_out <= !p_write_r; // see R2 see R3 see R10
					xfer_direction_oe_out <= !p_write_r; // see R2 see R3 see R10
					data_xcvr_enable_oe_out <= state_nxt != lbus_pkg::ADDR_ST; // see R4
					byte_lane_enables_oe_out <= contig(p_lanes_r[{idx_nxt, 2'h0} +: 4]); // see R12 see R13 see R21
				end
				default: begin
					write_not_read_oe_out <= 1'b0;
					xfer_direction_oe_out <= 1'b0;
					data_xcvr_enable_oe_out <= 1'b0;
					byte_lane_enables_oe_out <= lbus_pkg::LANES_OFF;
				end
			endcase
		end
	end

	// Open-drain pins only ever pull low
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			od_low_r <= 1'b0;
		end else begin
			od_low_r <= 1'b0;
		end
	end
	assign addr_state_strobe_n_out = od_low_r;
	assign write_not_read_out = od_low_r;
	assign xfer_direction_out = od_low_r;
	assign data_xcvr_enable_n_out = od_low_r;
	assign byte_lane_enables_n_out = {4{od_low_r}};

	// Read word capture into the FIFO
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			push_valid_r <= 1'b0;
			push_data_r <= lbus_pkg::LAD_RESET;
		end else begin
			push_valid_r <= ready_seen && !p_write_r; // see R7
			if (ready_seen) begin
				push_data_r <= addr_data_lines_in; // see R7
			end
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_word_stall;
		phase_w && in_xfer && ready_n_in;
	endsequence
	sequence s_word_done;
		phase_w && in_xfer && !ready_n_in;
	endsequence

	AST_ADDR_DRIVE: assert property (state_r == lbus_pkg::ADDR_ST |-> // see R1
		!addr_latch_strobe_n_out && addr_state_strobe_oe_out && addr_data_lines_oe_out
		&& addr_data_lines_out[31:2] == p_addr_r) else $error("address state outputs wrong");
	AST_READ_DIR: assert property (state_r == lbus_pkg::ADDR_ST && !p_write_r |-> // see R2
		write_not_read_oe_out && xfer_direction_oe_out) else $error("read direction wrong");
	AST_WRITE_DIR: assert property (state_r == lbus_pkg::ADDR_ST && p_write_r |-> // see R3
		!write_not_read_oe_out && !xfer_direction_oe_out) else $error("write direction wrong");
	AST_DEN: assert property (in_xfer |-> data_xcvr_enable_oe_out) else $error("transceiver enable missing"); // see R4
	AST_WAIT_ENTRY: assert property (s_word_stall |=> state_r == lbus_pkg::WAIT_ST) else $error("no wait state"); // see R5
	AST_CAPTURE: assert property (s_word_done ##0 !p_write_r |=> // see R7
		push_valid_r && push_data_r == $past(addr_data_lines_in)) else $error("read word lost");
	AST_RECOVERY: assert property ($rose(state_r == lbus_pkg::RECOV_ST) |-> // see R8
		(state_r == lbus_pkg::RECOV_ST)[*2] ##1 state_r != lbus_pkg::RECOV_ST) else $error("recovery length wrong");
	AST_WDATA_HOLD: assert property (state_r == lbus_pkg::WAIT_ST && p_write_r |-> // see R9
		addr_data_lines_oe_out && $stable(addr_data_lines_out)) else $error("write word moved in wait");
	AST_CTRL_STABLE: assert property (s_word_stall |=> $stable(write_not_read_oe_out) // see R10
		&& $stable(xfer_direction_oe_out) && $stable(data_xcvr_enable_oe_out)) else $error("control moved in wait");
	AST_BURST_STEP: assert property (s_word_done ##0 !last_word |=> // see R11
		state_r == lbus_pkg::DATA_ST && word_idx_r == 2'($past(word_idx_r) + 2'h1)) else $error("burst step wrong");
	AST_LANES_HOLD: assert property (s_word_stall |=> $stable(byte_lane_enables_oe_out)) else $error("lanes moved"); // see R12
	AST_CACHE_HOLD: assert property (in_xfer |-> $stable(cacheable_flag_out)) else $error("cacheable flag moved"); // see R14
	AST_SIZE_CODE: assert property (state_r == lbus_pkg::ADDR_ST |-> // see R20
		addr_data_lines_out[1:0] == p_size_r) else $error("size code wrong");
	AST_LANES_ADJ: assert property (byte_lane_enables_oe_out == contig(byte_lane_enables_oe_out)) else $error("lanes apart"); // see R21
	AST_HOLD_FLOAT: assert property (state_r == lbus_pkg::HOLD_ST |-> bus_grant_out // see R22
		&& !addr_data_lines_oe_out && !addr_latch_strobe_oe_out && byte_lane_enables_oe_out == 4'h0) else $error("hold not floated");
	AST_GRANT_DROP: assert property (phase_w && state_r == lbus_pkg::HOLD_ST && !bus_request_in |=> // see R22
		!bus_grant_out) else $error("grant not dropped");
	AST_IDLE_QUIET: assert property (state_r == lbus_pkg::IDLE_ST |-> // see R23
		!addr_state_strobe_oe_out && !data_xcvr_enable_oe_out) else $error("idle not quiet");
endmodule
`default_nettype wire

// File: verification/lbus_far_model.sv
// Far-side memory device model answering the local bus master
`timescale 1ns/1ns
`default_nettype none
module lbus_far_model (
	// Clock and master outputs
	input wire logic clk_in,
	input wire logic bcc_in,
	input wire logic [31:0] lad_in,
	input wire logic lad_oe_in,
	input wire logic ads_in,
	input wire logic den_in,
	input wire logic rd_in,
	input wire logic [3:0] lanes_in,
	// Wait states inserted before each word
	input wire logic [3:0] waits_in,
	// Answers to the master
	output logic [31:0] bus_out,
	output logic ready_n_out
);
	logic [31:0] mem_r [16];
	logic [31:0] last_r = 32'h0;
	logic [3:0] ptr_r = 4'h0;
	logic [3:0] wcnt_r = 4'h0;
	logic drv_r = 1'b0;
	// Wire level: master, model, else a pattern that changes each cycle
	assign bus_out = lad_oe_in ? lad_in : drv_r ? mem_r[ptr_r] : ~last_r;
	// Known contents at start
	initial begin
		ready_n_out = 1'b1;
		for (int i = 0; i < 16; i++) mem_r[i] = 32'hA5A5_0000 + 32'(i);
	end
	// Mid cycle: take address, answer data states; at the boundary let go
	always @(posedge clk_in) begin
		last_r <= bus_out;
		if (!bcc_in && ads_in) begin
			ptr_r <= lad_in[5:2];
		end
		if (!bcc_in && den_in && wcnt_r < waits_in) begin
			wcnt_r <= wcnt_r + 4'h1;
		end else if (!bcc_in && den_in) begin
			ready_n_out <= 1'b0;
			drv_r <= rd_in;
			for (int b = 0; b < 4; b++) begin
				if (!rd_in && lanes_in[b]) mem_r[ptr_r][8*b+:8] <= lad_in[8*b+:8];
			end
		end else if (bcc_in) begin
			ptr_r <= ptr_r + {3'h0, !ready_n_out};
			wcnt_r <= ready_n_out ? wcnt_r : 4'h0;
			ready_n_out <= 1'b1;
			drv_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: verification/test_local_bus_master_interface.sv
// Self-checking bench for the local bus master
`timescale 1ns/1ns
`default_nettype none
module test_local_bus_master_interface;
	typedef struct packed {
		logic wr;
		logic [1:0] sz;
		logic [3:0] a;
		logic [15:0] ln;
		logic [3:0] w;
		logic [4:0] dens;
	} row_s;
	// Ordinary cases: request fields, waits, and data or wait cycles expected
	localparam row_s rows [8] = '{
		'{1'b1, 2'h3, 4'h0, 16'hFFFF, 4'h0, 5'h04},
		'{1'b0, 2'h3, 4'h0, 16'hFFFF, 4'h0, 5'h04},
		'{1'b1, 2'h1, 4'h4, 16'h003C, 4'h1, 5'h04},
		'{1'b0, 2'h1, 4'h4, 16'h00FF, 4'h2, 5'h06},
		'{1'b1, 2'h0, 4'h9, 16'h0006, 4'h3, 5'h04},
		'{1'b0, 2'h2, 4'h8, 16'h0FFF, 4'h0, 5'h03},
		'{1'b1, 2'h2, 4'hD, 16'h0F8F, 4'h0, 5'h03},
		'{1'b0, 2'h0, 4'hE, 16'h000F, 4'h1, 5'h02}
	};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rq_v = 1'b0;
	logic rq_wr = 1'b0;
	logic rq_c = 1'b0;
	logic rd_rdy = 1'b1;
	logic bus_req = 1'b0;
	logic [1:0] rq_sz = 2'h0;
	logic [29:0] rq_a = 30'h0;
	logic [15:0] rq_ln = 16'h0;
	logic [127:0] rq_wd = 128'h0;
	logic [3:0] waits = 4'h0;
	logic rq_rdy, rd_v, lad_oe, latch_n, latch_oe, cache, cache_oe, addr_state_strobe, wnr, dir, data_xcvr_enable, ready_n, grant, bcc;
	logic [31:0] rd_d, lad_o, lad_i;
	logic [3:0] ln;
	logic [7:0] od;
	logic e_wr, e_c;
	logic dprev = 1'b0;
	logic gprev = 1'b0;
	logic [1:0] e_sz;
	logic [29:0] e_a;
	logic [15:0] e_ln;
	logic [127:0] e_wd;
	logic [31:0] mem_e [16];
	logic [31:0] got_q [$];
	logic [31:0] exp_q [$];
	int e_den = 0, den_cnt = 0, ads_cnt = 0, wi = 0, cyc = 0, miscompares = 0, tests_run = 0;
	// Clock at 100 MHz
	always #5 clk = ~clk;
	lbus_master dut (
		.ref_clk_in(clk), .rst_n_in(rst_n), .req_valid_in(rq_v), .req_ready_out(rq_rdy),
		.req_addr_in(rq_a), .req_size_in(rq_sz), .req_write_in(rq_wr), .req_cache_in(rq_c),
		.req_lanes_in(rq_ln), .req_wdata_in(rq_wd), .rd_valid_out(rd_v), .rd_data_out(rd_d),
		.rd_ready_in(rd_rdy), .addr_data_lines_in(lad_i), .addr_data_lines_out(lad_o),
		.addr_data_lines_oe_out(lad_oe), .addr_latch_strobe_n_out(latch_n),
		.addr_latch_strobe_oe_out(latch_oe), .cacheable_flag_out(cache), .cacheable_flag_oe_out(cache_oe),
		.addr_state_strobe_n_out(od[0]), .addr_state_strobe_oe_out(addr_state_strobe), .write_not_read_out(od[1]),
		.write_not_read_oe_out(wnr), .xfer_direction_out(od[2]), .xfer_direction_oe_out(dir),
		.data_xcvr_enable_n_out(od[3]), .data_xcvr_enable_oe_out(data_xcvr_enable), .byte_lane_enables_n_out(od[7:4]),
		.byte_lane_enables_oe_out(ln), .ready_n_in(ready_n), .bus_request_in(bus_req),
		.bus_grant_out(grant), .bus_cycle_clock_out(bcc)
	);
	lbus_far_model far (
		.clk_in(clk), .bcc_in(bcc), .lad_in(lad_o), .lad_oe_in(lad_oe), .ads_in(addr_state_strobe), .den_in(data_xcvr_enable),
		.rd_in(wnr), .lanes_in(ln), .waits_in(waits), .bus_out(lad_i), .ready_n_out(ready_n)
	);
	// Compare, count, report a mismatch
	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Bus monitor: mid-cycle state outputs, word tracking, grant timing, read capture
	always @(posedge clk) begin
		if (rst_n && !bcc) begin
			if (addr_state_strobe) ads_cnt++;
			if (addr_state_strobe) check({lad_o, lad_oe, latch_n, wnr, dir, cache, ln}, {e_a, e_sz, 2'h2, !e_wr, !e_wr, e_c, e_ln[3:0]});
			if (data_xcvr_enable) den_cnt++;
			if (data_xcvr_enable) check({addr_state_strobe, lad_oe, wnr, dir, ln}, {1'b0, e_wr, !e_wr, !e_wr, e_ln[4*wi+:4]});
			if (data_xcvr_enable && e_wr) check(lad_o, e_wd[32*wi+:32]);
			if (addr_state_strobe || data_xcvr_enable) check(od, 8'h0);
			if (dprev && !data_xcvr_enable) check({lad_oe, addr_state_strobe, ln, wnr, dir}, 8'h0);
			dprev <= data_xcvr_enable;
		end
		if (rst_n && bcc && data_xcvr_enable && !ready_n) wi <= wi + 1;
		if (rst_n && grant && !gprev) check(den_cnt, e_den);
		gprev <= grant;
		if (rd_v && rd_rdy) got_q.push_back(rd_d);
	end
	// One transfer; mode 1 offers it in hold, 2 raises hold mid-burst, 3 expects a read buffer without room for the burst
	task automatic run(input row_s r, input logic [7:0] s, input logic [1:0] mode);
		int ads0;
		ads0 = ads_cnt;
		e_wr = r.wr;
		e_sz = r.sz;
		e_a = {26'h2B4_C3E1, r.a};
		e_ln = r.ln;
		e_c = s[0];
		e_den = int'(r.dens);
		den_cnt = 0;
		wi = 0;
		for (int k = 0; k <= r.sz; k++) begin
			e_wd[32*k+:32] = 32'hDA7A_0000 + 32'(s * 4 + k);
			if (!r.wr) exp_q.push_back(mem_e[4'(r.a + k)]);
			for (int b = 0; b < 4; b++) begin
				if (r.wr && r.ln[4*k+b]) mem_e[4'(r.a + k)][8*b+:8] = e_wd[32*k+8*b+:8];
			end
		end
		waits <= r.w;
		rq_wr <= r.wr;
		rq_sz <= r.sz;
		rq_a <= e_a;
		rq_ln <= r.ln;
		rq_c <= e_c;
		rq_wd <= e_wd;
		rq_v <= 1'b1;
		// In hold the request is taken at once; drop it before it is taken twice
		if (mode == 2'h1) begin
			repeat (10) @(posedge clk);
			check({grant, rq_rdy, 8'(ads_cnt)}, {2'h2, 8'(ads0)});
			bus_req <= 1'b0;
		end else begin
			do @(posedge clk); while (rq_rdy !== 1'b1);
		end
		rq_v <= 1'b0;
		if (mode == 2'h2) begin
			repeat (6) @(posedge clk);
			bus_req <= 1'b1;
		end
		if (mode == 2'h3) begin
			repeat (40) @(posedge clk);
			check(ads_cnt, ads0);
			rd_rdy <= 1'b1;
		end
		do @(posedge clk); while (rq_rdy !== 1'b1);
		check(den_cnt, e_den);
		check(ads_cnt, ads0 + 1);
		if (mode == 2'h2) begin
			repeat (8) @(posedge clk);
			check(grant, 1'b1);
			bus_req <= 1'b0;
			repeat (4) @(posedge clk);
			check(grant, 1'b0);
		end
	endtask
	// Compare collected read words with the mirror
	task automatic drain(input string name);
		repeat (24) @(posedge clk);
		check(got_q.size(), exp_q.size());
		while (exp_q.size() > 0 && got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
		got_q.delete();
		exp_q.delete();
		$display("test %s done", name);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			print_verdict();
		end
	end
	// Main sequence
	initial begin
		for (int i = 0; i < 16; i++) mem_e[i] = 32'hA5A5_0000 + 32'(i);
		repeat (5) @(posedge clk);
		check({rq_rdy, grant, rd_v, bcc, lad_oe, addr_state_strobe, data_xcvr_enable, latch_oe, latch_n, cache_oe}, 10'h7);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 check(bcc, 1'b1);
		@(posedge clk);
		#1 check(bcc, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			run(rows[i], 8'(i), 2'h0);
			drain("row");
		end
		bus_req <= 1'b1;
		repeat (8) @(posedge clk);
		check({grant, lad_oe, latch_oe, cache_oe, addr_state_strobe, wnr, dir, data_xcvr_enable, ln}, 12'h800);
		run(rows[3], 8'h20, 2'h1);
		run(rows[0], 8'h21, 2'h2);
		drain("hold");
		rd_rdy <= 1'b0;
		for (int i = 0; i < 4; i++) run(rows[1], 8'(9 + i), 2'h0);
		run(rows[1], 8'h30, 2'h3);
		drain("fifo");
		check(rd_v, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
